// File: verif/pdlc_pin_model.sv
// Far-side pin model: external device driving released port pins
`timescale 1ns/1ns

module pdlc_pin_model #(
  parameter int W = 8  // Pins on this port
) (
  input  wire logic [W-1:0] oe_b_i,   // Enable from block, low drives
  input  wire logic [W-1:0] pin_o_i,  // Latch from block
  input  wire logic [W-1:0] ext_i,    // Level the external device drives
  output logic      [W-1:0] level_o   // Resolved pad level
);
  // Block wins where enabled; the external part only drives released pads
  always_comb begin
    // No pull-up modelled: pins in analog mode keep theirs off
    level_o = (oe_b_i & ext_i) | (~oe_b_i & pin_o_i);
  end
endmodule : pdlc_pin_model

// File: verif/port_direction_latch_control_test.sv
// Self-checking bench for the port direction and latch block
`timescale 1ns/1ns
`include "pdlc_defines.svh"

module port_direction_latch_control_test;
  import pdlc_pkg::*;
  logic clk, rst_b, wr, rd, bm, c2_pin, c2_o, c2_oe, c4, c2_ext;
  logic [15:0] addr;   // Bus address
  logic [2:0]  bsel;   // Bit number
  logic [7:0]  wdata, rdata, d_pin, d_o, d_oe, d_ext;
  logic [3:0]  b_pin, b_o, b_oe, b_ext, ana;
  logic [1:0]  irq;    // Request pulses
  int          bad_count;
  int          samples_checked;

  // ****************************************************************
  // Clock, design and far-side models
  // ****************************************************************
  initial clk = 1'b0;
  always #25 clk = ~clk;  // 20 MHz

  pdlc_top pdlc_top_inst (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .BUS_ADDR_I(addr), .BUS_WR_I(wr), .BUS_RD_I(rd),
    .BUS_BIT_I(bm), .BUS_BIT_SEL_I(bsel), .BUS_WDATA_I(wdata), .BUS_RDATA_O(rdata),
    .PORT_B_PIN_I(b_pin), .PORT_B_PIN_O(b_o), .PORT_B_OE_B_O(b_oe),
    .PORT_C_PIN2_I(c2_pin), .PORT_C_PIN2_O(c2_o), .PORT_C_PIN2_OE_B_O(c2_oe),
    .PORT_C_PIN4_I(c4), .PORT_D_PIN_I(d_pin), .PORT_D_PIN_O(d_o), .PORT_D_OE_B_O(d_oe),
    .ANALOG_SEL_O(ana), .EXT_IRQ_REQ_O(irq));
  pdlc_pin_model #(.W(4)) pdlc_pin_model_b_inst (
    .oe_b_i(b_oe), .pin_o_i(b_o), .ext_i(b_ext), .level_o(b_pin));
  pdlc_pin_model #(.W(1)) pdlc_pin_model_c_inst (
    .oe_b_i(c2_oe), .pin_o_i(c2_o), .ext_i(c2_ext), .level_o(c2_pin));
  pdlc_pin_model #(.W(8)) pdlc_pin_model_d_inst (
    .oe_b_i(d_oe), .pin_o_i(d_o), .ext_i(d_ext), .level_o(d_pin));

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Strobe one cycle; idle edge first so no strobe is set twice in a step
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d, input logic b = 1'b0,
                        input logic [2:0] s = 3'h0);
    @(posedge clk);
    #1;
    addr = a; wdata = d; bm = b; bsel = s; wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0; bm = 1'b0;
  endtask : bus_wr

  task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    addr = a; rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    chk(what, exp, rdata);
  endtask : rd_chk

  task automatic report_and_stop;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset state of pads and registers; released pads read back live
  task automatic t_reset;
    chk("d_oe", 8'hff, d_oe);
    chk("b_oe", 8'h0f, {4'h0, b_oe});
    chk("d_latch", 8'h00, d_o);
    chk("ana_pins", 8'h00, {4'h0, ana});
    rd_chk("b_dir", `PDLC_ADDR_B_DIR, 8'hff);
    rd_chk("c_dir", `PDLC_ADDR_C_DIR, 8'hff);
    rd_chk("d_dir", `PDLC_ADDR_D_DIR, 8'hff);
    rd_chk("b_data", `PDLC_ADDR_B_DATA, 8'h05);
    rd_chk("c_data", `PDLC_ADDR_C_DATA, 8'h14);
    rd_chk("d_data", `PDLC_ADDR_D_DATA, 8'h3c);
    rd_chk("ana_reg", `PDLC_ADDR_B_ANA, 8'h00);
    rd_chk("unmapped", 16'hff10, 8'h00);
  endtask : t_reset

  // Latch write in input mode, then mixed direction read view
  task automatic t_output;
    bus_wr(`PDLC_ADDR_D_DATA, 8'h5a);
    chk("d_latch_in", 8'h5a, d_o);
    chk("d_oe_in", 8'hff, d_oe);
    rd_chk("d_pin_view", `PDLC_ADDR_D_DATA, 8'h3c);
    bus_wr(`PDLC_ADDR_D_DIR, 8'h0f);
    chk("d_oe_mix", 8'h0f, d_oe);
    chk("d_pad_mix", 8'h5c, d_pin);
    rd_chk("d_mix_view", `PDLC_ADDR_D_DATA, 8'h5c);
  endtask : t_output

  // Single-bit writes merge the read view into the latch
  task automatic t_bit;
    bus_wr(`PDLC_ADDR_D_DATA, 8'h01, 1'b1, 3'h0);
    chk("d_latch_bit", 8'h5d, d_o);
    bus_wr(`PDLC_ADDR_D_DIR, 8'h00, 1'b1, 3'h0);
    rd_chk("d_dir_bit", `PDLC_ADDR_D_DIR, 8'h0e);
    chk("d_oe_bit", 8'h0e, d_oe);
    rd_chk("d_bit_view", `PDLC_ADDR_D_DATA, 8'h5d);
  endtask : t_bit

  // Analog routing overrides the digital driver and read path
  task automatic t_analog;
    // Direction still one: proper analog input setup, pads show level 5
    bus_wr(`PDLC_ADDR_B_ANA, 8'hff);
    rd_chk("ana_rd", `PDLC_ADDR_B_ANA, 8'h0f);
    chk("ana_on", 8'h0f, {4'h0, ana});
    rd_chk("b_data_ana", `PDLC_ADDR_B_DATA, 8'h00);
    bus_wr(`PDLC_ADDR_B_DIR, 8'h00);
    chk("b_oe_ana", 8'h0f, {4'h0, b_oe});
    bus_wr(`PDLC_ADDR_B_ANA, 8'h00, 1'b1, 3'h2);
    rd_chk("ana_bit", `PDLC_ADDR_B_ANA, 8'h0b);
    chk("b_oe_part", 8'h0b, {4'h0, b_oe});
    // Direction, latch and analog all zero: timer output setup
    bus_wr(`PDLC_ADDR_B_ANA, 8'h00);
    chk("b_oe_dig", 8'h00, {4'h0, b_oe});
  endtask : t_analog

  // Level changes on the shared pins raise one-cycle requests
  task automatic t_irq;
    bus_wr(`PDLC_ADDR_B_DATA, 8'h02);
    chk("irq_b", 8'h01, {6'h0, irq});
    chk("b_latch", 8'h02, {4'h0, b_o});
    bus_wr(`PDLC_ADDR_B_DATA, 8'h02);
    chk("irq_b_same", 8'h00, {6'h0, irq});
    // Request mask is taken as set upstream before the pin turns output
    bus_wr(`PDLC_ADDR_C_DIR, 8'h00);
    rd_chk("c_dir_rd", `PDLC_ADDR_C_DIR, 8'hfb);
    chk("c2_oe", 8'h00, {7'h0, c2_oe});
    bus_wr(`PDLC_ADDR_C_DATA, 8'hff);
    chk("irq_c", 8'h02, {6'h0, irq});
    c4 = 1'b0;
    rd_chk("c_data_rd", `PDLC_ADDR_C_DATA, 8'h04);
    chk("c2_pad", 8'h01, {7'h0, c2_pin});
  endtask : t_irq

  // Mid-run reset puts every register back, whatever was written before
  task automatic t_rerst;
    bus_wr(`PDLC_ADDR_B_ANA, 8'h05);
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk("d_oe_rst", 8'hff, d_oe);
    chk("c2_oe_rst", 8'h01, {7'h0, c2_oe});
    chk("d_latch_rst", 8'h00, d_o);
    chk("b_latch_rst", 8'h00, {4'h0, b_o});
    chk("c2_latch_rst", 8'h00, {7'h0, c2_o});
    chk("ana_rst", 8'h00, {4'h0, ana});
    chk("irq_rst", 8'h00, {6'h0, irq});
    rd_chk("b_dir_rst", `PDLC_ADDR_B_DIR, 8'hff);
    rd_chk("ana_reg_rst", `PDLC_ADDR_B_ANA, 8'h00);
  endtask : t_rerst

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    bad_count = 0;
    samples_checked = 0;
    rst_b = 1'b0; wr = 1'b0; rd = 1'b0; bm = 1'b0; bsel = 3'h0;
    addr = 16'h0000; wdata = 8'h00; c4 = 1'b1;
    b_ext = 4'h5; c2_ext = 1'b1; d_ext = 8'h3c;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_output();
    t_bit();
    t_analog();
    t_irq();
    t_rerst();
    report_and_stop();
  end

  // Whole run is well under 200 cycles; allow ten times that
  initial begin
    #(50 * 2000);
    bad_count++;
    report_and_stop();
  end
endmodule : port_direction_latch_control_test

// File: verilog/pdlc_defines.svh
// Register offsets, field masks, reset values and timing for the port control block
`ifndef PDLC_DEFINES_SVH
`define PDLC_DEFINES_SVH

// ****************************************************************
// Register byte addresses on the CPU memory bus
// ****************************************************************
`define PDLC_ADDR_B_DATA   16'hff02
`define PDLC_ADDR_C_DATA   16'hff03
`define PDLC_ADDR_D_DATA   16'hff04
`define PDLC_ADDR_B_DIR    16'hff22
`define PDLC_ADDR_C_DIR    16'hff23
`define PDLC_ADDR_D_DIR    16'hff24
`define PDLC_ADDR_B_ANA    16'hff84

// ****************************************************************
// Reset values
// ****************************************************************
`define PDLC_RST_DIR       8'hff
`define PDLC_RST_DATA      8'h00
`define PDLC_RST_ANA       8'h00

// ****************************************************************
// Field masks: implemented, input-only and analog pins per port
// ****************************************************************
`define PDLC_B_IMPL_MASK   8'h0f
`define PDLC_C_IMPL_MASK   8'h04
`define PDLC_C_RO_MASK     8'h10
`define PDLC_D_IMPL_MASK   8'hff
`define PDLC_NO_RO_MASK    8'h00
`define PDLC_ANA_MASK      8'h0f

// ****************************************************************
// Pin positions and timing
// ****************************************************************
`define PDLC_B_IRQ_PIN     1
`define PDLC_C_IRQ_PIN     2
`define PDLC_C_RO_PIN      4
`define PDLC_RD_LATENCY    1

`endif

// File: verilog/pdlc_pkg.sv
// Types shared by the port control block
package pdlc_pkg;

  // ****************************************************************
  // Register selected by the bus address
  // ****************************************************************
  typedef enum logic [2:0] {
    PDLC_SEL_NONE   = 3'h0,
    PDLC_SEL_B_DATA = 3'h1,
    PDLC_SEL_C_DATA = 3'h3,
    PDLC_SEL_D_DATA = 3'h2,
    PDLC_SEL_B_DIR  = 3'h6,
    PDLC_SEL_C_DIR  = 3'h7,
    PDLC_SEL_D_DIR  = 3'h5,
    PDLC_SEL_B_ANA  = 3'h4
  } pdlc_sel_type;

endpackage : pdlc_pkg

// File: verilog/pdlc_port.sv
// One port: direction register, output latch, read mux and pin drivers
`timescale 1ns/1ns
`include "pdlc_defines.svh"

module pdlc_port
  import pdlc_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK = 8'hff, // Pins with latch and direction bit
  parameter logic [7:0] RO_MASK   = 8'h00  // Input-only pins
) (
  input  wire logic       clk_i,       // Core clock
  input  wire logic       rst_b_i,     // Synchronous reset, active low
  input  wire logic       dir_we_i,    // Write strobe, direction register
  input  wire logic       dat_we_i,    // Write strobe, data register
  input  wire logic       bit_mode_i,  // Single-bit access
  input  wire logic [2:0] bit_sel_i,   // Bit number for single-bit access
  input  wire logic [7:0] wdata_i,     // Write data
  input  wire logic [7:0] ana_q_i,     // Analog select, current
  input  wire logic [7:0] ana_nxt_i,   // Analog select, next
  input  wire logic [7:0] pin_i,       // Pin levels
  output logic      [7:0] dir_o,       // Direction register
  output logic      [7:0] dat_rd_o,    // Data register read value
  output logic      [7:0] pin_o,       // Output latch to pins
  output logic      [7:0] oe_b_o,      // Output enable, low drives
  output logic      [7:0] lat_nxt_o,   // Latch next value
  output logic      [7:0] oe_b_nxt_o   // Output enable next value
);

  logic [7:0] dir_r, dir_nxt;          // Direction bits, 1 is input
  logic [7:0] lat_r, lat_nxt;          // Output latch
  logic [7:0] oe_b_r, oe_b_nxt;        // Registered buffer enable
  logic [7:0] dat_rd;                  // Read view
  logic [7:0] merged;                  // Read-modify-write result

  // ****************************************************************
  // Read view and next-state logic
  // ****************************************************************
  always_comb begin
    // Input mode or input-only shows pin; analog pins read zero
    dat_rd = (((dir_r & ~ana_q_i & pin_i) | (~dir_r & ~ana_q_i & lat_r)) & IMPL_MASK)
           | (pin_i & RO_MASK);
    // Bit access still moves a whole byte, so other input pins take their level
    merged = dat_rd;
    merged[bit_sel_i] = wdata_i[bit_sel_i];
    dir_nxt = dir_r;
    if (dir_we_i) begin
      // Unimplemented direction bits stay at one
      if (bit_mode_i) begin
        dir_nxt[bit_sel_i] = wdata_i[bit_sel_i];
      end else begin
        dir_nxt = wdata_i;
      end
      dir_nxt = dir_nxt | ~IMPL_MASK;
    end
    lat_nxt = lat_r;
    if (dat_we_i) begin
      // Latch keeps writes even in input mode; input-only bit ignores them
      lat_nxt = (bit_mode_i ? merged : wdata_i) & IMPL_MASK;
    end
    // Buffer on only for output mode and not analog
    oe_b_nxt = dir_nxt | ana_nxt_i | ~IMPL_MASK;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dir_r  <= `PDLC_RST_DIR;
      lat_r  <= `PDLC_RST_DATA;
      oe_b_r <= 8'hff;
    end else begin
      dir_r  <= dir_nxt;
      lat_r  <= lat_nxt;
      oe_b_r <= oe_b_nxt;
    end
  end

  assign dir_o      = dir_r;
  assign dat_rd_o   = dat_rd;
  assign pin_o      = lat_r;
  assign oe_b_o     = oe_b_r;
  assign lat_nxt_o  = lat_nxt;
  assign oe_b_nxt_o = oe_b_nxt;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_latch_byte_write: assert property (dat_we_i && !bit_mode_i |=>
    lat_r == ($past(wdata_i) & IMPL_MASK))
    else $error("Latch did not take byte write");
  a_oe_from_dir: assert property (##1 oe_b_r == (dir_r | ana_q_i | ~IMPL_MASK))
    else $error("Buffer enable disagrees with direction");
  a_input_only_clear: assert property ((lat_r & RO_MASK) == 8'h00)
    else $error("Input-only bit held a latch value");
  a_dir_fixed_ones: assert property ((dir_r | IMPL_MASK) == 8'hff)
    else $error("Unimplemented direction bit cleared");

endmodule : pdlc_port

// File: verilog/pdlc_top.sv
// Port direction, latch and analog-select control for three GPIO ports
`timescale 1ns/1ns
`include "pdlc_defines.svh"

module pdlc_top
  import pdlc_pkg::*;
(
  input  wire logic        CORE_CLK_I,          // Core clock, 20 MHz
  input  wire logic        RST_B_I,             // Synchronous reset, active low
  input  wire logic [15:0] BUS_ADDR_I,          // CPU byte address
  input  wire logic        BUS_WR_I,            // Write strobe
  input  wire logic        BUS_RD_I,            // Read strobe
  input  wire logic        BUS_BIT_I,           // Single-bit access
  input  wire logic [2:0]  BUS_BIT_SEL_I,       // Bit number for bit access
  input  wire logic [7:0]  BUS_WDATA_I,         // Write data
  output logic      [7:0]  BUS_RDATA_O,         // Read data, one cycle after strobe
  input  wire logic [3:0]  PORT_B_PIN_I,        // Port B pin levels
  output logic      [3:0]  PORT_B_PIN_O,        // Port B output latch
  output logic      [3:0]  PORT_B_OE_B_O,       // Port B enable, low drives
  input  wire logic        PORT_C_PIN2_I,       // Port C pin 2 level
  output logic             PORT_C_PIN2_O,       // Port C pin 2 latch
  output logic             PORT_C_PIN2_OE_B_O,  // Port C pin 2 enable, low drives
  input  wire logic        PORT_C_PIN4_I,       // Input-only pin shared with reset
  input  wire logic [7:0]  PORT_D_PIN_I,        // Port D pin levels
  output logic      [7:0]  PORT_D_PIN_O,        // Port D output latch
  output logic      [7:0]  PORT_D_OE_B_O,       // Port D enable, low drives
  output logic      [3:0]  ANALOG_SEL_O,        // Port B pins routed to converter
  output logic      [1:0]  EXT_IRQ_REQ_O        // Request pulses, shared pins
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pdlc_sel_type sel;                     // Decoded register
  logic [7:0]   ana_r, ana_nxt;          // Analog select
  logic [7:0]   rdata_r, rdata_nxt;      // Registered read data
  logic [1:0]   irq_r, irq_nxt;          // Request pulses
  logic [7:0]   c_pins;                  // Port C pins as a byte
  logic [7:0]   b_pins;                  // Port B pins as a byte
  logic [7:0]   b_dir, c_dir, d_dir;     // Direction registers
  logic [7:0]   b_rd, c_rd, d_rd;        // Data read views
  logic [7:0]   b_pin, c_pin, d_pin;     // Latch outputs
  logic [7:0]   b_oe, c_oe, d_oe;        // Buffer enables, low drives
  logic [7:0]   b_lnx, c_lnx, d_lnx;     // Latch next values
  logic [7:0]   b_onx, c_onx, d_onx;     // Enable next values
  logic         we_b_dat;                // Write strobe, port B latch
  logic         we_c_dat;                // Write strobe, port C latch
  logic         we_d_dat;                // Write strobe, port D latch
  logic         we_b_dir;                // Write strobe, port B direction
  logic         we_c_dir;                // Write strobe, port C direction
  logic         we_d_dir;                // Write strobe, port D direction

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    // Unmapped addresses select nothing and read zero
    unique case (BUS_ADDR_I)
      `PDLC_ADDR_B_DATA: sel = PDLC_SEL_B_DATA;
      `PDLC_ADDR_C_DATA: sel = PDLC_SEL_C_DATA;
      `PDLC_ADDR_D_DATA: sel = PDLC_SEL_D_DATA;
      `PDLC_ADDR_B_DIR:  sel = PDLC_SEL_B_DIR;
      `PDLC_ADDR_C_DIR:  sel = PDLC_SEL_C_DIR;
      `PDLC_ADDR_D_DIR:  sel = PDLC_SEL_D_DIR;
      `PDLC_ADDR_B_ANA:  sel = PDLC_SEL_B_ANA;
      default:           sel = PDLC_SEL_NONE;
    endcase
  end

  // Write strobes per register
  assign we_b_dat = BUS_WR_I && (sel == PDLC_SEL_B_DATA);
  assign we_c_dat = BUS_WR_I && (sel == PDLC_SEL_C_DATA);
  assign we_d_dat = BUS_WR_I && (sel == PDLC_SEL_D_DATA);
  assign we_b_dir = BUS_WR_I && (sel == PDLC_SEL_B_DIR);
  assign we_c_dir = BUS_WR_I && (sel == PDLC_SEL_C_DIR);
  assign we_d_dir = BUS_WR_I && (sel == PDLC_SEL_D_DIR);

  // Pins gathered into bytes; unused positions read low
  assign b_pins = {4'h0, PORT_B_PIN_I};
  assign c_pins = {3'h0, PORT_C_PIN4_I, 1'b0, PORT_C_PIN2_I, 2'h0};

  // ****************************************************************
  // Port instances
  // ****************************************************************
  pdlc_port #(.IMPL_MASK(`PDLC_B_IMPL_MASK), .RO_MASK(`PDLC_NO_RO_MASK)) u_port_b (
    .clk_i      (CORE_CLK_I),
    .rst_b_i    (RST_B_I),
    .dir_we_i   (we_b_dir),
    .dat_we_i   (we_b_dat),
    .bit_mode_i (BUS_BIT_I),
    .bit_sel_i  (BUS_BIT_SEL_I),
    .wdata_i    (BUS_WDATA_I),
    .ana_q_i    (ana_r),
    .ana_nxt_i  (ana_nxt),
    .pin_i      (b_pins),
    .dir_o      (b_dir),
    .dat_rd_o   (b_rd),
    .pin_o      (b_pin),
    .oe_b_o     (b_oe),
    .lat_nxt_o  (b_lnx),
    .oe_b_nxt_o (b_onx)
  );

  // Port C has no analog pins
  pdlc_port #(.IMPL_MASK(`PDLC_C_IMPL_MASK), .RO_MASK(`PDLC_C_RO_MASK)) u_port_c (
    .clk_i      (CORE_CLK_I),
    .rst_b_i    (RST_B_I),
    .dir_we_i   (we_c_dir),
    .dat_we_i   (we_c_dat),
    .bit_mode_i (BUS_BIT_I),
    .bit_sel_i  (BUS_BIT_SEL_I),
    .wdata_i    (BUS_WDATA_I),
    .ana_q_i    (8'h00),
    .ana_nxt_i  (8'h00),
    .pin_i      (c_pins),
    .dir_o      (c_dir),
    .dat_rd_o   (c_rd),
    .pin_o      (c_pin),
    .oe_b_o     (c_oe),
    .lat_nxt_o  (c_lnx),
    .oe_b_nxt_o (c_onx)
  );

  pdlc_port #(.IMPL_MASK(`PDLC_D_IMPL_MASK), .RO_MASK(`PDLC_NO_RO_MASK)) u_port_d (
    .clk_i      (CORE_CLK_I),
    .rst_b_i    (RST_B_I),
    .dir_we_i   (we_d_dir),
    .dat_we_i   (we_d_dat),
    .bit_mode_i (BUS_BIT_I),
    .bit_sel_i  (BUS_BIT_SEL_I),
    .wdata_i    (BUS_WDATA_I),
    .ana_q_i    (8'h00),
    .ana_nxt_i  (8'h00),
    .pin_i      (PORT_D_PIN_I),
    .dir_o      (d_dir),
    .dat_rd_o   (d_rd),
    .pin_o      (d_pin),
    .oe_b_o     (d_oe),
    .lat_nxt_o  (d_lnx),
    .oe_b_nxt_o (d_onx)
  );

  // ****************************************************************
  // Analog select, read mux and request next values
  // ****************************************************************
  always_comb begin
    ana_nxt = ana_r;
    if (BUS_WR_I && (sel == PDLC_SEL_B_ANA)) begin
      // Bit or byte write; upper nibble cannot be set
      if (BUS_BIT_I) begin
        ana_nxt[BUS_BIT_SEL_I] = BUS_WDATA_I[BUS_BIT_SEL_I];
      end else begin
        ana_nxt = BUS_WDATA_I;
      end
      ana_nxt = ana_nxt & `PDLC_ANA_MASK;
    end
    // Whole byte is always returned; bit reads pick from it
    rdata_nxt = rdata_r;
    if (BUS_RD_I) begin
      unique case (sel)
        PDLC_SEL_B_DATA: rdata_nxt = b_rd;
        PDLC_SEL_C_DATA: rdata_nxt = c_rd;
        PDLC_SEL_D_DATA: rdata_nxt = d_rd;
        PDLC_SEL_B_DIR:  rdata_nxt = b_dir;
        PDLC_SEL_C_DIR:  rdata_nxt = c_dir;
        PDLC_SEL_D_DIR:  rdata_nxt = d_dir;
        PDLC_SEL_B_ANA:  rdata_nxt = ana_r;
        PDLC_SEL_NONE:   rdata_nxt = 8'h00;
      endcase
    end
    // Pulse when a driven shared pin changes level and stays driven
    irq_nxt[0] = !b_oe[`PDLC_B_IRQ_PIN] && !b_onx[`PDLC_B_IRQ_PIN]
               && (b_pin[`PDLC_B_IRQ_PIN] != b_lnx[`PDLC_B_IRQ_PIN]);
    irq_nxt[1] = !c_oe[`PDLC_C_IRQ_PIN] && !c_onx[`PDLC_C_IRQ_PIN]
               && (c_pin[`PDLC_C_IRQ_PIN] != c_lnx[`PDLC_C_IRQ_PIN]);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      ana_r   <= `PDLC_RST_ANA;
      rdata_r <= 8'h00;
      irq_r   <= 2'h0;
    end else begin
      ana_r   <= ana_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign BUS_RDATA_O        = rdata_r;
  assign PORT_B_PIN_O       = b_pin[3:0];
  assign PORT_B_OE_B_O      = b_oe[3:0];
  assign PORT_C_PIN2_O      = c_pin[`PDLC_C_IRQ_PIN];
  assign PORT_C_PIN2_OE_B_O = c_oe[`PDLC_C_IRQ_PIN];
  assign PORT_D_PIN_O       = d_pin;
  assign PORT_D_OE_B_O      = d_oe;
  assign ANALOG_SEL_O       = ana_r[3:0];
  assign EXT_IRQ_REQ_O      = irq_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  // Reset release followed by the register values
  sequence s_reset_release;
    $rose(RST_B_I);
  endsequence

  // Shared pin driven now and next cycle, with its latch about to change level
  sequence s_b1_driven_toggle;
    !b_oe[1] && !b_onx[1] ##0 (b_lnx[1] != b_pin[1]);
  endsequence

  // Port C shared pin, same shape as port B
  sequence s_c2_driven_toggle;
    !c_oe[2] && !c_onx[2] ##0 (c_lnx[2] != c_pin[2]);
  endsequence

  a_dir_reset_ones: assert property (@(posedge CORE_CLK_I)
    s_reset_release |-> (b_dir & d_dir & c_dir) == 8'hff)
    else $error("Direction not all ones after reset");
  a_latch_reset_zero: assert property (@(posedge CORE_CLK_I)
    s_reset_release |-> (b_pin | c_pin | d_pin) == 8'h00)
    else $error("Latch not zero after reset");
  a_ana_reset_zero: assert property (@(posedge CORE_CLK_I)
    s_reset_release |-> ana_r == 8'h00 ##1 ANALOG_SEL_O == $past(ana_nxt[3:0]))
    else $error("Analog select wrong after reset");
  a_ana_upper_zero: assert property (ana_r[7:4] == 4'h0)
    else $error("Analog select upper bits set");
  a_irq_on_toggle: assert property (s_b1_driven_toggle |=> EXT_IRQ_REQ_O[0])
    else $error("No request on driven level change");
  a_irq_needs_drive: assert property (EXT_IRQ_REQ_O[1] |->
    !$past(c_oe[2]) && (c_pin[2] != $past(c_pin[2])))
    else $error("Request without driven change");
  a_analog_floats: assert property (ana_r[0] |-> b_oe[0])
    else $error("Analog pin still driven");
  a_read_dir_byte: assert property (BUS_RD_I && sel == PDLC_SEL_D_DIR |=>
    BUS_RDATA_O == $past(d_dir))
    else $error("Direction read data wrong");
  a_read_input_pin: assert property (BUS_RD_I && sel == PDLC_SEL_D_DATA && d_dir[0] |=>
    BUS_RDATA_O[0] == $past(PORT_D_PIN_I[0]))
    else $error("Input-mode read did not return pin");
  // Port C request follows a driven change too
  a_irq_c_on_toggle: assert property (
    s_c2_driven_toggle |=> EXT_IRQ_REQ_O[1])
    else $error("No port C request on driven level change");
  // Port B request never comes from a released pin
  a_irq_b_needs_drive: assert property (
    EXT_IRQ_REQ_O[0] |-> !$past(b_oe[1]) && (b_pin[1] != $past(b_pin[1])))
    else $error("Port B request without driven change");
  // Output-mode bit reads back the latch, not the pad
  a_read_latch_out: assert property (
    BUS_RD_I && sel == PDLC_SEL_D_DATA && !d_dir[0] |=> BUS_RDATA_O[0] == $past(d_pin[0]))
    else $error("Output-mode read did not return latch");
  // Input-only pin always shows its live level
  a_read_ro_pin: assert property (
    BUS_RD_I && sel == PDLC_SEL_C_DATA |=> BUS_RDATA_O[`PDLC_C_RO_PIN] == $past(PORT_C_PIN4_I))
    else $error("Input-only pin read wrong");
  // Analog pins hide their level from the data register
  a_read_ana_zero: assert property (
    BUS_RD_I && sel == PDLC_SEL_B_DATA && ana_r[0] |=> !BUS_RDATA_O[0])
    else $error("Analog pin read as digital");
  // Unmapped addresses answer with zero
  a_unmapped_zero: assert property (
    BUS_RD_I && sel == PDLC_SEL_NONE |=> BUS_RDATA_O == 8'h00)
    else $error("Unmapped read not zero");
  // Upper analog bits drop on byte writes
  a_ana_byte_write: assert property (
    BUS_WR_I && sel == PDLC_SEL_B_ANA && !BUS_BIT_I |=> ana_r == ($past(BUS_WDATA_I) & `PDLC_ANA_MASK))
    else $error("Analog byte write not masked");
  // A byte write to the full-width direction register lands as written
  a_dir_d_write: assert property (
    BUS_WR_I && sel == PDLC_SEL_D_DIR && !BUS_BIT_I |=> d_dir == $past(BUS_WDATA_I))
    else $error("Direction byte write lost");

endmodule : pdlc_top
